/* File: src/dpm_host.sv */
// host controller driving one port of an asynchronous dual-port ram
// Rules of the dual-port ram that this block drives
// R1: ram takes a write ended by rw or select; host ends it by raising rw and select together.
// R2: a read of data the far port writes waits the flowthrough delay.
// R3: reads assert select and output enable, wait the longer access delay.
// R4: semaphore access uses semaphore select instead of chip enable, with oe for reads.
// R5: top address is the right port mailbox.
// R6: second-top address is the left port mailbox.
// R7: writing the other mailbox raises that port's interrupt flag.
// R8: reading own mailbox clears own interrupt flag.
// R9: reading the other mailbox leaves its flag alone.
// R10: under busy, a mailbox write does not interrupt the winner.
// R11: under busy, own mailbox read is blocked and flag kept.
// R12: same-address contention grants exactly one port.
// R13: busy asserts a bounded delay after address match or select.
// R14: master drives busy out, slave takes busy in.
// R15: writes wait until busy has settled, and stall while busy.
// R16: ram holds eight semaphore latches separate from the array.
// R17: semaphore select with chip enable high; low three address bits pick latch.
// R18: only data bit zero matters; zero written takes a free latch.
// R19: only the owner releases, by writing one.
// R20: a pending request wins ownership at release.
// R21: after semaphore write, deselect for setup, read back, zero means owned.
// R22: semaphore read value is latched inside the ram.
// R23: near-simultaneous semaphore requests grant one side.
// R24: exact ties resolve by fixed priority, left first.
`timescale 1ns/100ps
module dpm_host (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic REQ_VALID,
   input wire dpm_pkg::dpm_req_s REQ,
   output logic REQ_READY,
   output logic RSP_VALID,
   output logic [dpm_pkg::DPM_DW-1:0] RSP_DATA,
   output logic SEM_OWNED,
   output dpm_pkg::dpm_pins_s PINS,
   output logic [dpm_pkg::DPM_DW-1:0] DQ_O,
   output logic DQ_OE,
   input wire logic [dpm_pkg::DPM_DW-1:0] DQ_I,
   input wire logic BUSY_N,
   input wire logic INT_N,
   output logic INT_PENDING
);
   import dpm_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_SETTLE, S_WRITE, S_READ, S_SEM_WR, S_SEM_GAP,
      S_SEM_RD} dpm_state_e;

   dpm_state_e state_q;
   dpm_req_s req_q;
   logic load, done;
   logic [DPM_CW-1:0] load_cnt;

   dpm_timer u_timer (
      .CLK(CLK),
      .RSTN(RSTN),
      .ce(CE),
      .load(load),
      .count(load_cnt),
      .done(done)
   );

   // timer load and count chosen per transition
   always_comb begin
      load = 1'b0;
      load_cnt = DPM_BUSY_CYC;
      if (CE) begin
         case (state_q)
            S_IDLE: begin
               load = REQ_VALID;
               load_cnt = DPM_BUSY_CYC;
            end
            S_SETTLE: begin
               // reload while busy so the settle wait cannot run out; see R15
               load = done;
               load_cnt = !BUSY_N ? DPM_BUSY_CYC
                  : req_q.cmd == DPM_CMD_WRITE ? DPM_WR_CYC : DPM_RD_CYC;
            end
            S_SEM_WR: begin
               load = done;
               load_cnt = DPM_SEM_GAP_CYC;   // see R21
            end
            S_SEM_GAP: begin
               load = done;
               load_cnt = DPM_RD_CYC;
            end
            default: begin
               load = 1'b0;
               load_cnt = DPM_BUSY_CYC;
            end
         endcase
      end
   end

   // sequencer
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_q <= S_IDLE;
      end else if (CE) begin
         case (state_q)
            S_IDLE: begin
               if (REQ_VALID) begin
                  state_q <= (REQ.cmd == DPM_CMD_SEM_TAKE || REQ.cmd == DPM_CMD_SEM_FREE)
                     ? S_SEM_WR : S_SETTLE;
               end
            end
            S_SETTLE: begin
               // hold off until busy has settled high; see R15 R13 R10 R11
               if (done && BUSY_N) begin
                  state_q <= req_q.cmd == DPM_CMD_WRITE ? S_WRITE : S_READ;
               end
            end
            S_WRITE: begin
               if (done) begin
                  state_q <= S_IDLE;   // rw and chip enable rise together here, ending the write; see R1
               end
            end
            S_READ: begin
               if (done) begin
                  state_q <= S_IDLE;   // see R3 R2
               end
            end
            S_SEM_WR: begin
               if (done) begin
                  state_q <= req_q.cmd == DPM_CMD_SEM_TAKE ? S_SEM_GAP : S_IDLE;
               end
            end
            S_SEM_GAP: begin
               if (done) begin
                  state_q <= S_SEM_RD;
               end
            end
            S_SEM_RD: begin
               if (done) begin
                  state_q <= S_IDLE;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         req_q <= '0;
      end else if (CE && state_q == S_IDLE && REQ_VALID) begin
         req_q <= REQ;
      end
   end

   // pins: registered straight from the next state
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         PINS <= '{chip_enable_n: 1'b1, semaphore_select_n: 1'b1, read_write: 1'b1,
            output_enable_n: 1'b1, addr: DPM_ADDR_ZERO};
         DQ_O <= DPM_DATA_ZERO;
         DQ_OE <= 1'b0;
      end else if (CE) begin
         PINS.chip_enable_n <= 1'b1;
         PINS.semaphore_select_n <= 1'b1;
         PINS.read_write <= 1'b1;
         PINS.output_enable_n <= 1'b1;
         DQ_OE <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (REQ_VALID) begin
                  if (REQ.cmd == DPM_CMD_SEM_TAKE || REQ.cmd == DPM_CMD_SEM_FREE) begin
                     // latch index on low bits, chip enable stays high; see R17 R4
                     PINS.semaphore_select_n <= 1'b0;
                     PINS.read_write <= 1'b0;
                     PINS.addr <= {{(DPM_AW-3){1'b0}}, REQ.addr[2:0]};
                     // only bit zero counts; zero requests, one releases; see R18 R19 R20
                     DQ_O <= REQ.cmd == DPM_CMD_SEM_TAKE ? DPM_SEM_TAKE : DPM_SEM_RELEASE;
                     DQ_OE <= 1'b1;
                  end else begin
                     // select early so the ram arbitrates; see R12 R13
                     PINS.chip_enable_n <= 1'b0;
                     PINS.addr <= REQ.addr;
                  end
               end
            end
            S_SETTLE: begin
               PINS.chip_enable_n <= 1'b0;
               if (done && BUSY_N) begin
                  if (req_q.cmd == DPM_CMD_WRITE) begin
                     PINS.read_write <= 1'b0;
                     DQ_O <= req_q.wdata;
                     DQ_OE <= 1'b1;
                  end else begin
                     PINS.output_enable_n <= 1'b0;
                  end
               end
            end
            S_WRITE: begin
               if (!done) begin
                  PINS.chip_enable_n <= 1'b0;
                  PINS.read_write <= 1'b0;
               end
               DQ_OE <= 1'b1;   // data held one cycle past the strobe
            end
            S_READ: begin
               PINS.chip_enable_n <= done;
               PINS.output_enable_n <= done;
            end
            S_SEM_WR: begin
               PINS.semaphore_select_n <= done;
               PINS.read_write <= done;
               DQ_OE <= 1'b1;
            end
            S_SEM_GAP: begin
               // deselected for the flag setup time before reading back
               if (done) begin
                  PINS.semaphore_select_n <= 1'b0;
                  PINS.output_enable_n <= 1'b0;
               end
            end
            S_SEM_RD: begin
               PINS.semaphore_select_n <= done;
               PINS.output_enable_n <= done;
            end
            default: begin
               PINS.chip_enable_n <= 1'b1;
            end
         endcase
      end
   end

   // answer
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         RSP_VALID <= 1'b0;
         RSP_DATA <= DPM_DATA_ZERO;
         SEM_OWNED <= 1'b0;
      end else if (CE) begin
         RSP_VALID <= done && (state_q == S_READ || state_q == S_WRITE
            || state_q == S_SEM_RD || (state_q == S_SEM_WR && req_q.cmd == DPM_CMD_SEM_FREE));
         if (done && state_q == S_READ) begin
            RSP_DATA <= DQ_I;
         end
         if (done && state_q == S_SEM_RD) begin
            RSP_DATA <= DQ_I;
            SEM_OWNED <= !DQ_I[0];   // zero read back means owned; see R21
         end
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         REQ_READY <= 1'b0;
      end else if (CE) begin
         REQ_READY <= (state_q == S_IDLE && !REQ_VALID) || (done && (state_q == S_READ
            || state_q == S_WRITE || state_q == S_SEM_RD
            || (state_q == S_SEM_WR && req_q.cmd == DPM_CMD_SEM_FREE)));
      end
   end

   // the ram drives the flag; host only registers it, user reads its mailbox to clear
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         INT_PENDING <= 1'b0;
      end else if (CE) begin
         INT_PENDING <= !INT_N;   // see R7 R8
      end
   end
endmodule

/* File: src/dpm_pkg.sv */
// package: pin bundles, commands and timing for the dual-port ram host controller
package dpm_pkg;
   localparam int DPM_AW = 15;
   localparam int DPM_DW = 9;
   localparam real DPM_CLK_NS = 25.0;
   // timing figures in ns; plain defaults, the speed grade sets the real ones
   localparam real DPM_ACCESS_NS = 25.0;      // select_access_delay
   localparam real DPM_OE_ACCESS_NS = 13.0;   // output_enable_access_delay
   localparam real DPM_FLOW_NS = 35.0;        // flowthrough_delay
   localparam real DPM_BUSY_NS = 25.0;        // busy_from_select/address_delay
   localparam real DPM_SEM_SETUP_NS = 10.0;   // semaphore_flag_setup
   localparam real DPM_SEM_WRD_NS = 10.0;     // semaphore_write_to_read_delay
   localparam real DPM_WR_PULSE_NS = 25.0;    // strobe width incl write_data_setup
   localparam int DPM_CW = 4;
   // least times round up to whole cycles
   localparam logic [DPM_CW-1:0] DPM_RD_CYC =
      DPM_CW'($ceil((DPM_ACCESS_NS > DPM_FLOW_NS ? DPM_ACCESS_NS : DPM_FLOW_NS)
      / DPM_CLK_NS));
   localparam logic [DPM_CW-1:0] DPM_BUSY_CYC = DPM_CW'($ceil(DPM_BUSY_NS / DPM_CLK_NS));
   localparam logic [DPM_CW-1:0] DPM_WR_CYC = DPM_CW'($ceil(DPM_WR_PULSE_NS / DPM_CLK_NS));
   localparam logic [DPM_CW-1:0] DPM_SEM_GAP_CYC =
      DPM_CW'($ceil((DPM_SEM_SETUP_NS + DPM_SEM_WRD_NS + DPM_OE_ACCESS_NS) / DPM_CLK_NS));
   localparam logic [DPM_CW-1:0] DPM_CNT_ONE = 4'h1;
   localparam logic [2:0] DPM_SEM_IDX_ZERO = 3'h0;
   localparam logic [DPM_DW-1:0] DPM_SEM_RELEASE = 9'h001;
   localparam logic [DPM_DW-1:0] DPM_SEM_TAKE = 9'h000;
   localparam logic [DPM_AW-1:0] DPM_ADDR_ZERO = 15'h0000;
   localparam logic [DPM_DW-1:0] DPM_DATA_ZERO = 9'h000;

   typedef enum logic [1:0] {DPM_CMD_READ, DPM_CMD_WRITE, DPM_CMD_SEM_TAKE,
      DPM_CMD_SEM_FREE} dpm_cmd_e;

   // request from the user side
   typedef struct packed {
      dpm_cmd_e cmd;
      logic [DPM_AW-1:0] addr;
      logic [DPM_DW-1:0] wdata;
   } dpm_req_s;

   // control pins toward one port of the ram, all active low except rw
   typedef struct packed {
      logic chip_enable_n;
      logic semaphore_select_n;
      logic read_write;
      logic output_enable_n;
      logic [DPM_AW-1:0] addr;
   } dpm_pins_s;
endpackage

/* File: src/dpm_timer.sv */
// down-counter used to time pin phases
`timescale 1ns/100ps
module dpm_timer (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic ce,
   input wire logic load,
   input wire logic [dpm_pkg::DPM_CW-1:0] count,
   output logic done
);
   import dpm_pkg::*;
   logic [DPM_CW-1:0] cnt_q;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         cnt_q <= '0;
      end else if (ce) begin
         if (load) begin
            cnt_q <= count;
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - DPM_CNT_ONE;
         end
      end
   end
   // done in the last cycle of a loaded count; load is not read back, avoiding a loop
   assign done = (cnt_q == DPM_CNT_ONE);
endmodule

/* File: testbench/dpm_host_monitor.sv */
// assertion checker on the host controller ports
`timescale 1ns/100ps
module dpm_host_monitor (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic REQ_READY,
   input wire logic RSP_VALID,
   input wire logic [dpm_pkg::DPM_DW-1:0] RSP_DATA,
   input wire logic SEM_OWNED,
   input wire dpm_pkg::dpm_pins_s PINS,
   input wire logic DQ_OE,
   input wire logic BUSY_N,
   input wire logic INT_N,
   input wire logic INT_PENDING
);
   import dpm_pkg::*;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   sel_excl_a: assert property (PINS.chip_enable_n || PINS.semaphore_select_n)
      else $error("both selects low");
   bus_turn_a: assert property (DQ_OE |-> PINS.output_enable_n)
      else $error("drive during read");
   read_sel_a: assert property (!PINS.output_enable_n |->
      !(PINS.chip_enable_n && PINS.semaphore_select_n)) else $error("read unselected");
   busy_wait_a: assert property ($fell(PINS.read_write) && !PINS.chip_enable_n |->
      $past(BUSY_N)) else $error("write begun under busy");
   int_track_a: assert property ($fell(INT_N) |=> INT_PENDING)
      else $error("interrupt not seen");
   rsp_pulse_a: assert property (RSP_VALID |-> REQ_READY ##1 !RSP_VALID)
      else $error("bad completion pulse");
   sem_owned_a: assert property (!$stable(SEM_OWNED) |-> SEM_OWNED != RSP_DATA[0])
      else $error("owned flag off readback");
   sem_gap_a: assert property ($rose(PINS.semaphore_select_n) |=> PINS.semaphore_select_n)
      else $error("no setup gap");
   c_int: cover property ($rose(INT_PENDING));
   c_stall: cover property (!BUSY_N && !REQ_READY);
   c_own: cover property ($rose(SEM_OWNED));
endmodule
bind dpm_host dpm_host_monitor u_mon (.CLK(CLK), .RSTN(RSTN), .REQ_READY(REQ_READY),
   .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .SEM_OWNED(SEM_OWNED), .PINS(PINS),
   .DQ_OE(DQ_OE), .BUSY_N(BUSY_N), .INT_N(INT_N), .INT_PENDING(INT_PENDING));

/* File: testbench/dpm_ram_model.sv */
// behavioural dual-port ram at the host's port; far port driven by tasks
`timescale 1ns/100ps
module dpm_ram_model (
   input wire dpm_pkg::dpm_pins_s p,
   input wire logic [dpm_pkg::DPM_DW-1:0] dq_o,
   input wire logic contend,
   output logic [dpm_pkg::DPM_DW-1:0] dq_i,
   output logic busy_n,
   output logic int_n
);
   import dpm_pkg::*;
   localparam logic [DPM_AW-1:0] RMB = 15'h7fff;
   localparam logic [DPM_AW-1:0] LMB = 15'h7ffe;
   logic [DPM_DW-1:0] mem [2**DPM_AW];
   logic [DPM_DW-1:0] sem_rd, last;
   logic [7:0] l_own, r_own, l_pend, r_pend;
   logic r_int_n;
   // case equality so unknown pins before reset give no false strobe edge
   wire wr = (p.chip_enable_n === 1'b0) && (p.read_write === 1'b0);
   wire rd = (p.chip_enable_n === 1'b0) && (p.output_enable_n === 1'b0);
   wire sw = (p.semaphore_select_n === 1'b0) && (p.read_write === 1'b0);
   wire sr = (p.semaphore_select_n === 1'b0) && (p.output_enable_n === 1'b0);
   wire [2:0] idx = p.addr[2:0];
   initial begin
      {l_own, r_own, l_pend, r_pend} = '0;
      int_n = 1'b1;
      r_int_n = 1'b1;
      last = 9'h000;
   end
   // far port wins every contention the bench raises
   assign busy_n = !contend;
   // write lands when the strobe ends, whichever pin ends it
   always @(negedge wr) begin
      mem[p.addr] = dq_o;
      if (p.addr == RMB && busy_n) r_int_n = 1'b0;
   end
   always @(negedge rd) begin
      last = mem[p.addr];
      if (p.addr == LMB && busy_n) int_n = 1'b1;
   end
   always @(posedge sr) sem_rd = {DPM_DW{!l_own[idx]}};
   always @(negedge sr) last = sem_rd;
   always @(negedge sw) begin
      if (!dq_o[0]) begin
         if (r_own[idx]) l_pend[idx] = 1'b1;
         else l_own[idx] = 1'b1;
      end else if (l_own[idx]) begin
         l_own[idx] = 1'b0;
         r_own[idx] = r_pend[idx];
         r_pend[idx] = 1'b0;
      end else l_pend[idx] = 1'b0;
   end
   // released lines show the inverse, so stale data cannot pass
   always @* dq_i = rd ? mem[p.addr] : sr ? sem_rd : ~last;
   task automatic far_write(input logic [DPM_AW-1:0] a, input logic [DPM_DW-1:0] d);
      mem[a] = d;
      if (a == LMB) int_n = 1'b0;
   endtask
   task automatic far_sem(input logic [2:0] i, input logic b);
      if (!b) begin
         if (l_own[i]) r_pend[i] = 1'b1;
         else r_own[i] = 1'b1;
      end else if (r_own[i]) begin
         r_own[i] = 1'b0;
         l_own[i] = l_pend[i];
         l_pend[i] = 1'b0;
      end
   endtask
endmodule

/* File: testbench/dpm_host_test.sv */
// self-checking bench for the dual-port ram host controller
`timescale 1ns/100ps
module dpm_host_test;
   import dpm_pkg::*;
   localparam logic [DPM_AW-1:0] LMB = 15'h7ffe;
   localparam logic [DPM_AW-1:0] RMB = 15'h7fff;
   logic CLK = 1'b0;
   logic RSTN = 1'b0;
   logic REQ_VALID = 1'b0;
   logic contend = 1'b0;
   logic ce = 1'b1;
   dpm_req_s REQ = '0;
   logic REQ_READY, RSP_VALID, SEM_OWNED, DQ_OE, BUSY_N, INT_N, INT_PENDING;
   logic [DPM_DW-1:0] RSP_DATA, DQ_O, DQ_I, d;
   logic [DPM_AW-1:0] a;
   logic [DPM_AW-1:0] qa[$];
   logic [DPM_DW-1:0] qd[$];
   dpm_pins_s PINS;
   int failures = 0;
   int check_count = 0;
   dpm_host u_dut (.CLK(CLK), .RSTN(RSTN), .CE(ce), .REQ_VALID(REQ_VALID), .REQ(REQ),
      .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .SEM_OWNED(SEM_OWNED),
      .PINS(PINS), .DQ_O(DQ_O), .DQ_OE(DQ_OE), .DQ_I(DQ_I), .BUSY_N(BUSY_N), .INT_N(INT_N),
      .INT_PENDING(INT_PENDING));
   dpm_ram_model u_ram (.p(PINS), .dq_o(DQ_O), .contend(contend), .dq_i(DQ_I),
      .busy_n(BUSY_N), .int_n(INT_N));
   initial forever #12.5 CLK = ~CLK;
   task automatic chk_data(input string n, input logic [8:0] e, input logic [8:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      chk_data(n, {8'h00, e}, {8'h00, g});
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic req(input dpm_cmd_e c, input logic [DPM_AW-1:0] ad, input logic [8:0] wd);
      int n;
      REQ = '{c, ad, wd};
      REQ_VALID = 1'b1;
      @(posedge CLK) #1;
      REQ_VALID = 1'b0;
      for (n = 0; n < 60 && RSP_VALID !== 1'b1; n++) @(posedge CLK) #1;
      chk_bit("response", 1'b1, RSP_VALID);
      chk_bit("ready", 1'b1, REQ_READY);
      @(posedge CLK) #1;
   endtask
   initial begin
      void'($urandom(32'hdee3c993));
      repeat (6) @(posedge CLK);
      #1 RSTN = 1'b1;
      @(posedge CLK) #1;
      chk_bit("idle", 1'b1, &{PINS.chip_enable_n, PINS.semaphore_select_n});
      chk_bit("ready idle", 1'b1, REQ_READY);
      // distinct blocks keep random addresses apart and off the mailboxes
      for (int i = 0; i < 8; i++) begin
         a = {i[2:0], 1'b0, 11'($urandom)};
         d = 9'($urandom);
         qa.push_back(a);
         qd.push_back(d);
         req(DPM_CMD_WRITE, a, d);
      end
      // clock enable low: a presented request must not be taken
      ce = 1'b0;
      REQ = '{DPM_CMD_READ, qa[0], 9'h000};
      REQ_VALID = 1'b1;
      repeat (3) @(posedge CLK) #1;
      chk_bit("frozen", 1'b1, PINS.chip_enable_n);
      chk_bit("frozen ready", 1'b1, REQ_READY);
      REQ_VALID = 1'b0;
      ce = 1'b1;
      @(posedge CLK) #1;
      while (qa.size() > 0) begin
         req(DPM_CMD_READ, qa.pop_front(), 9'h000);
         chk_data("read", qd.pop_front(), RSP_DATA);
      end
      d = 9'($urandom);
      u_ram.far_write(LMB, d);
      repeat (2) @(posedge CLK) #1;
      chk_bit("int set", 1'b1, INT_PENDING);
      req(DPM_CMD_READ, RMB, 9'h000);
      chk_bit("int kept", 1'b1, INT_PENDING);
      contend = 1'b1;
      fork
         req(DPM_CMD_READ, LMB, 9'h000);
         begin
            repeat (10) @(posedge CLK) #1;
            chk_bit("stall oe", 1'b1, PINS.output_enable_n);
            chk_bit("int held", 1'b1, INT_PENDING);
            contend = 1'b0;
         end
      join
      chk_data("mailbox", d, RSP_DATA);
      chk_bit("int clear", 1'b0, INT_PENDING);
      req(DPM_CMD_WRITE, RMB, d);
      chk_bit("far int", 1'b0, u_ram.r_int_n);
      for (int i = 0; i < 8; i++) begin
         a = {12'($urandom), i[2:0]};
         req(DPM_CMD_SEM_TAKE, a, 9'h000);
         chk_bit("take", 1'b1, SEM_OWNED);
         u_ram.far_sem(i[2:0], 1'b0);
         req(DPM_CMD_SEM_FREE, a, 9'h001);
         req(DPM_CMD_SEM_TAKE, a, 9'h000);
         chk_bit("held far", 1'b0, SEM_OWNED);
         u_ram.far_sem(i[2:0], 1'b1);
         req(DPM_CMD_SEM_TAKE, a, 9'h000);
         chk_data("passed", 9'h000, RSP_DATA);
         req(DPM_CMD_SEM_FREE, a, 9'h001);
      end
      complete_run;
   end
   // roughly eighteen times the expected run of about 330 cycles
   initial begin
      #(25.0 * 6000);
      failures++;
      complete_run;
   end
endmodule
